// *** core/fcc_pkg.sv ***
package fcc_pkg;

  // ***********************************************************
  // register map and fields
  // ***********************************************************
  localparam logic [7:0] FCC_OFF_COMMAND = 8'h00;
  localparam logic [7:0] FCC_OFF_CONFIG = 8'h04;
  localparam logic [7:0] FCC_OFF_IRQ_FLAGS = 8'h14;
  localparam logic [7:0] FCC_OFF_STATUS = 8'h18;

  localparam logic [7:0] FCC_KEY = 8'ha5;
  localparam int FCC_KEY_LSB = 8;
  localparam int FCC_CMD_W = 7;

  localparam logic [31:0] FCC_CONFIG_RESET = 32'h0000_0080;
  localparam logic [31:0] FCC_CONFIG_MASK = 32'h0007_039e;
  localparam int FCC_MANUAL_BIT = 7;
  localparam int FCC_WAIT_LSB = 1;
  localparam int FCC_SLEEP_LSB = 8;
  localparam int FCC_POLICY_LSB = 16;
  localparam int FCC_CACHE_OFF_BIT = 18;

  // irq_flags bits: 0 ready, 1 error; status bits
  localparam int FCC_FLAG_READY = 0;
  localparam int FCC_FLAG_ERROR = 1;
  localparam int FCC_ST_POWER = 0;
  localparam int FCC_ST_PROG = 2;
  localparam int FCC_ST_LOCK = 3;
  localparam int FCC_ST_FAULT = 4;

  // ***********************************************************
  // command codes
  // ***********************************************************
  localparam logic [6:0] FCC_ROW_WIPE_CMD = 7'h02;
  localparam logic [6:0] FCC_PAGE_PROGRAM_CMD = 7'h04;
  localparam logic [6:0] FCC_AUX_ROW_WIPE_CMD = 7'h05;
  localparam logic [6:0] FCC_AUX_PAGE_PROGRAM_CMD = 7'h06;
  localparam logic [6:0] FCC_LOCK_BITS_STORE_CMD = 7'h0f;
  localparam logic [6:0] FCC_EMULATED_ROW_WIPE_CMD = 7'h1a;
  localparam logic [6:0] FCC_EMULATED_PAGE_PROGRAM_CMD = 7'h1c;
  localparam logic [6:0] FCC_REGION_LOCK_CMD = 7'h40;
  localparam logic [6:0] FCC_REGION_UNLOCK_CMD = 7'h41;
  localparam logic [6:0] FCC_POWER_REDUCTION_ON_CMD = 7'h42;
  localparam logic [6:0] FCC_POWER_REDUCTION_OFF_CMD = 7'h43;
  localparam logic [6:0] FCC_PAGE_BUFFER_CLEAR_CMD = 7'h44;
  localparam logic [6:0] FCC_SECURITY_SET_CMD = 7'h45;
  localparam logic [6:0] FCC_CACHE_FLUSH_CMD = 7'h46;
  localparam logic [7:0] FCC_SECURITY_BYTE = 8'h00;

  // fetch policy codes
  localparam logic [1:0] FCC_MISS_NO_STALL = 2'h0;
  localparam logic [1:0] FCC_MISS_LOW_POWER = 2'h1;
  localparam logic [1:0] FCC_MISS_EQUAL_TIME = 2'h2;

  typedef enum {FCC_IDLE, FCC_PEND, FCC_RUN} fcc_state_e;

  // request to the flash array sequencer
  typedef struct packed {
    logic valid;
    logic [6:0] code;
    logic [7:0] data;
  } fcc_mem_req_s;

  // read path configuration for the cache and fetch logic
  typedef struct packed {
    logic cache_on;
    logic [1:0] fetch_policy;
    logic [3:0] flash_wait_states;
    logic [3:0] hit_wait;
    logic [3:0] miss_wait;
    logic [1:0] sleep_mode;
  } fcc_read_cfg_s;

endpackage

// *** core/fcc_top.sv ***
// Summary of operation
// - command runs only with key 0xa5 written
// - wrong key blocks command, sets program error
// - key while command busy sets program error
// - fetch bus access wins; command waits idle
// - key bit 0 reads one until issued
// - code 0x02 wipes main-array row
// - code 0x04 programs page buffer to page
// - aux wipe/program need clear security, user row
// - code 0x0f stores lock bits
// - 0x1a/0x1c wipe/program emulated array
// - 0x40 locks, 0x41 unlocks addressed region
// - 0x42 enters, 0x43 leaves power reduction
// - code 0x44 clears page buffer
// - 0x45 sets security, first byte zero
// - code 0x46 invalidates every cache line
// - config bit 18 set disables cache
// - policy 0 adds no miss wait
// - policy 1 adds one miss wait
// - policy 2 equal hit/miss time; 3 reserved
// - wait states zero to fifteen, reset zero
// - auto page write unless manual bit set, busy or key written same cycle
// - error flag on any error, write-one clears
`timescale 1ns/1ps

module fcc_top
  import fcc_pkg::*;
(
  input wire logic core_clk, // 125 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte lanes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb unmapped address
  input wire logic ahb_busy, // fetch bus access this cycle
  input wire logic mem_busy, // flash array busy
  input wire logic mem_done, // flash array op finished, pulse
  input wire logic security_bit, // chip security set
  input wire logic addr_in_user_row, // address hits user config row
  input wire logic lock_violation, // locked region hit, pulse
  input wire logic memory_fault, // array fault, pulse
  input wire logic pbuf_last_word, // last page buffer word written, pulse
  output fcc_mem_req_s mem_req, // command to flash array
  output logic cache_flush, // invalidate all lines, pulse
  output logic pbuf_clear, // clear page buffer, pulse
  output logic power_reduced, // power reduction mode level
  output fcc_read_cfg_s read_cfg // cache and fetch settings
);

  // ***********************************************************
  // reset release
  // ***********************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_ok_n;

  // async assert, release after two edges
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_ok_n = rst_sync_reg;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic fcc_code_known(input logic [6:0] c);
    logic k;
    k = 1'b0;
    case (c)
      FCC_ROW_WIPE_CMD, FCC_PAGE_PROGRAM_CMD, FCC_AUX_ROW_WIPE_CMD,
      FCC_AUX_PAGE_PROGRAM_CMD, FCC_LOCK_BITS_STORE_CMD,
      FCC_EMULATED_ROW_WIPE_CMD, FCC_EMULATED_PAGE_PROGRAM_CMD,
      FCC_REGION_LOCK_CMD, FCC_REGION_UNLOCK_CMD,
      FCC_POWER_REDUCTION_ON_CMD, FCC_POWER_REDUCTION_OFF_CMD,
      FCC_PAGE_BUFFER_CLEAR_CMD, FCC_SECURITY_SET_CMD, FCC_CACHE_FLUSH_CMD:
        k = 1'b1;
      default:
        k = 1'b0;
    endcase
    return k;
  endfunction

  // codes handled here without the array
  function automatic logic fcc_code_local(input logic [6:0] c);
    return c == FCC_POWER_REDUCTION_ON_CMD || c == FCC_POWER_REDUCTION_OFF_CMD ||
      c == FCC_PAGE_BUFFER_CLEAR_CMD || c == FCC_CACHE_FLUSH_CMD;
  endfunction

  // codes that change array contents
  function automatic logic fcc_code_alters(input logic [6:0] c);
    return c == FCC_ROW_WIPE_CMD || c == FCC_PAGE_PROGRAM_CMD ||
      c == FCC_AUX_ROW_WIPE_CMD || c == FCC_AUX_PAGE_PROGRAM_CMD ||
      c == FCC_EMULATED_ROW_WIPE_CMD || c == FCC_EMULATED_PAGE_PROGRAM_CMD;
  endfunction

  // ***********************************************************
  // apb decode
  // ***********************************************************
  logic wr_en;
  logic rd_setup;
  logic hit_cmd;
  logic hit_cfg;
  logic hit_flags;
  logic hit_status;
  logic mapped;
  logic key_write;
  logic key_ok;
  logic [6:0] wr_code;
  logic aux_code;
  logic aux_refused;
  logic [31:0] cfg_reg;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit_cmd = paddr == FCC_OFF_COMMAND;
  assign hit_cfg = paddr == FCC_OFF_CONFIG;
  assign hit_flags = paddr == FCC_OFF_IRQ_FLAGS;
  assign hit_status = paddr == FCC_OFF_STATUS;
  assign mapped = hit_cmd || hit_cfg || hit_flags || hit_status;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // key lane write; a key without its code lane counts as a bad key
  assign key_write = wr_en && hit_cmd && pstrb[1];
  assign key_ok = pwdata[FCC_KEY_LSB +: 8] == FCC_KEY && pstrb[0];
  assign wr_code = pwdata[FCC_CMD_W-1:0];
  assign aux_code = wr_code == FCC_AUX_ROW_WIPE_CMD || wr_code == FCC_AUX_PAGE_PROGRAM_CMD;
  assign aux_refused = aux_code && (security_bit || !addr_in_user_row);

  // ***********************************************************
  // command sequencer
  // ***********************************************************
  fcc_state_e state_reg;
  fcc_state_e state_next;
  logic [6:0] code_reg;
  logic [6:0] code_next;
  logic accept;
  logic auto_write;
  logic go;
  logic prog_err_set;
  logic busy;

  assign busy = state_reg != FCC_IDLE;
  // keyed, legal and ready
  assign accept = key_write && key_ok && !busy && fcc_code_known(wr_code) && !aux_refused;
  // page buffer filled with automatic writes on, only when nothing keyed
  assign auto_write = pbuf_last_word && !cfg_reg[FCC_MANUAL_BIT] && !busy && !key_write;
  // fetch bus and array must both be quiet
  assign go = state_reg == FCC_PEND && !ahb_busy && !mem_busy;
  assign prog_err_set = key_write && (!key_ok || busy || aux_refused);

  // next state
  always_comb
  begin
    state_next = state_reg;
    code_next = code_reg;
    unique case (state_reg)
      FCC_IDLE:
      begin
        if (accept)
        begin
          state_next = FCC_PEND;
          code_next = wr_code;
        end
        else if (auto_write)
        begin
          state_next = FCC_PEND;
          code_next = FCC_PAGE_PROGRAM_CMD;
        end
      end
      FCC_PEND:
      begin
        if (go)
          state_next = fcc_code_local(code_reg) ? FCC_IDLE : FCC_RUN;
      end
      FCC_RUN:
      begin
        if (mem_done)
          state_next = FCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_ok_n)
  begin
    if (!rst_ok_n)
    begin
      state_reg <= FCC_IDLE;
      code_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      code_reg <= code_next;
    end
  end

  // ***********************************************************
  // issue outputs
  // ***********************************************************
  logic go_array;
  logic go_flush;

  assign go_array = go && !fcc_code_local(code_reg);
  // content changes drop cached lines too
  assign go_flush = go && (code_reg == FCC_CACHE_FLUSH_CMD || fcc_code_alters(code_reg));

  // registered strobes, one cycle after the issue point
  always_ff @(posedge core_clk or negedge rst_ok_n)
  begin
    if (!rst_ok_n)
    begin
      mem_req <= '0;
      cache_flush <= 1'b0;
      pbuf_clear <= 1'b0;
      power_reduced <= 1'b0;
    end
    else
    begin
      mem_req.valid <= go_array;
      if (go_array)
      begin
        mem_req.code <= code_reg;
        mem_req.data <= FCC_SECURITY_BYTE;
      end
      cache_flush <= go_flush;
      pbuf_clear <= go && code_reg == FCC_PAGE_BUFFER_CLEAR_CMD;
      if (go && code_reg == FCC_POWER_REDUCTION_ON_CMD)
        power_reduced <= 1'b1;
      else if (go && code_reg == FCC_POWER_REDUCTION_OFF_CMD)
        power_reduced <= 1'b0;
    end
  end

  // ***********************************************************
  // configuration register
  // ***********************************************************
  logic [31:0] cfg_wmask;
  logic [1:0] policy;
  logic [3:0] wait_states;

  // byte lanes expand to bit mask, limited to defined fields
  assign cfg_wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}} &
    FCC_CONFIG_MASK;

  always_ff @(posedge core_clk or negedge rst_ok_n)
  begin
    if (!rst_ok_n)
      cfg_reg <= FCC_CONFIG_RESET;
    else if (wr_en && hit_cfg)
      cfg_reg <= (cfg_reg & ~cfg_wmask) | (pwdata & cfg_wmask);
  end

  assign policy = cfg_reg[FCC_POLICY_LSB +: 2];
  assign wait_states = cfg_reg[FCC_WAIT_LSB +: 4];

  // miss and hit timing seen by the fetch path; reserved policy acts as 0
  always_comb
  begin
    read_cfg.cache_on = !cfg_reg[FCC_CACHE_OFF_BIT];
    read_cfg.fetch_policy = policy;
    read_cfg.flash_wait_states = wait_states;
    read_cfg.sleep_mode = cfg_reg[FCC_SLEEP_LSB +: 2];
    read_cfg.hit_wait = 4'h0;
    read_cfg.miss_wait = 4'h0;
    if (policy == FCC_MISS_LOW_POWER)
      read_cfg.miss_wait = 4'h1;
    else if (policy == FCC_MISS_EQUAL_TIME)
    begin
      read_cfg.hit_wait = wait_states;
      read_cfg.miss_wait = wait_states;
    end
  end

  // ***********************************************************
  // error flags
  // ***********************************************************
  logic prog_err_reg;
  logic lock_err_reg;
  logic fault_err_reg;
  logic err_flag_reg;
  logic clr_flags;
  logic clr_status;

  // write one clears; a new event in the same cycle wins
  assign clr_flags = wr_en && hit_flags && pstrb[0] && pwdata[FCC_FLAG_ERROR];
  assign clr_status = wr_en && hit_status && pstrb[0];

  always_ff @(posedge core_clk or negedge rst_ok_n)
  begin
    if (!rst_ok_n)
    begin
      prog_err_reg <= 1'b0;
      lock_err_reg <= 1'b0;
      fault_err_reg <= 1'b0;
      err_flag_reg <= 1'b0;
    end
    else
    begin
      prog_err_reg <= prog_err_set || (prog_err_reg && !(clr_status && pwdata[FCC_ST_PROG]));
      lock_err_reg <= lock_violation || (lock_err_reg && !(clr_status && pwdata[FCC_ST_LOCK]));
      fault_err_reg <= memory_fault ||
        (fault_err_reg && !(clr_status && pwdata[FCC_ST_FAULT]));
      err_flag_reg <= prog_err_set || lock_violation || memory_fault ||
        (err_flag_reg && !clr_flags);
    end
  end

  // ***********************************************************
  // read data
  // ***********************************************************
  logic [31:0] rd_word;

  // key bit 0 shows a keyed command still waiting for issue
  assign rd_word = hit_cmd ? {16'h0, 7'h0, state_reg == FCC_PEND, 1'b0, code_reg} :
    hit_cfg ? cfg_reg :
    hit_flags ? {30'h0, err_flag_reg, !busy} :
    hit_status ? {27'h0, fault_err_reg, lock_err_reg, prog_err_reg, 1'b0, power_reduced} :
    32'h0;

  // captured in setup phase so prdata stays a flop output
  always_ff @(posedge core_clk or negedge rst_ok_n)
  begin
    if (!rst_ok_n)
      prdata <= '0;
    else if (rd_setup)
      prdata <= rd_word;
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_ok_n);

  sequence s_keyed_idle;
    key_write && key_ok && !busy && fcc_code_known(wr_code) && !aux_refused;
  endsequence

  sequence s_pending_blocked;
    state_reg == FCC_PEND && (ahb_busy || mem_busy);
  endsequence

  chk_bad_key_err: assert property (
    key_write && !key_ok |=> prog_err_reg && err_flag_reg && $stable(code_reg) &&
    ($past(busy) || state_reg == FCC_IDLE))
    else $error("bad key did not flag error");

  chk_busy_key_err: assert property (
    key_write && busy |=> prog_err_reg && $stable(code_reg))
    else $error("key while busy not flagged");

  chk_key_starts: assert property (
    s_keyed_idle |=> state_reg == FCC_PEND && code_reg == $past(wr_code))
    else $error("valid key did not start command");

  chk_fetch_priority: assert property (
    s_pending_blocked |=> !mem_req.valid && !cache_flush)
    else $error("command issued during fetch or busy array");

  chk_issue_timing: assert property (
    go && !fcc_code_local(code_reg) |=> mem_req.valid && mem_req.code == $past(code_reg))
    else $error("array request not issued one cycle after go");

  chk_reserved_code: assert property (
    key_write && key_ok && !busy && !fcc_code_known(wr_code) |=> state_reg == FCC_IDLE ##1
    !mem_req.valid)
    else $error("reserved code started an operation");

  chk_flush_pulse: assert property (
    go && code_reg == FCC_CACHE_FLUSH_CMD |=> cache_flush ##1 !cache_flush)
    else $error("flush not one pulse");

  chk_miss_policy: assert property (
    policy == FCC_MISS_LOW_POWER |-> read_cfg.miss_wait == 4'h1 && read_cfg.hit_wait == 4'h0)
    else $error("low power policy miss wait wrong");

  chk_err_clear: assert property (
    clr_flags && !prog_err_set && !lock_violation && !memory_fault |=> !err_flag_reg)
    else $error("error flag not cleared by write one");

  chk_auto_write: assert property (
    auto_write |=> state_reg == FCC_PEND && code_reg == FCC_PAGE_PROGRAM_CMD)
    else $error("auto page write not started");

endmodule

// *** sim/fcc_array_model.sv ***
`timescale 1ns/1ps

// ***********************************************************
// flash array model: takes one request, stays busy, then done
// ***********************************************************
module fcc_array_model
  import fcc_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire fcc_mem_req_s mem_req, // command from the sequencer
  input wire logic slow, // long array operation when high
  output logic mem_busy, // array busy level
  output logic mem_done, // one-cycle finish pulse
  output int req_count, // requests seen so far
  output logic [6:0] last_code, // code of the latest request
  output logic [7:0] last_data // data of the latest request
);
  int left;

  // slow mode keeps busy long enough for a second key to collide
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_busy <= 1'b0;
      mem_done <= 1'b0;
      req_count <= 0;
      last_code <= 7'h00;
      last_data <= 8'h00;
      left <= 0;
    end
    else
    begin
      mem_done <= 1'b0;
      if (mem_req.valid === 1'b1)
      begin
        req_count <= req_count + 1;
        last_code <= mem_req.code;
        last_data <= mem_req.data;
        mem_busy <= 1'b1;
        left <= slow ? 40 : 2;
      end
      else if (left > 1)
        left <= left - 1;
      else if (left == 1)
      begin
        left <= 0;
        mem_busy <= 1'b0;
        mem_done <= 1'b1;
      end
    end
  end
endmodule

// *** sim/flash_command_and_cache_config_bench.sv ***
`timescale 1ns/1ps

module flash_command_and_cache_config_bench
  import fcc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic ahb_busy = 1'b0;
  logic security_bit = 1'b0;
  logic addr_in_user_row = 1'b1;
  logic lock_violation = 1'b0;
  logic memory_fault = 1'b0;
  logic pbuf_last_word = 1'b0;
  logic slow = 1'b0;
  logic pready, pslverr, mem_busy, mem_done, cache_flush, pbuf_clear, power_reduced;
  logic [31:0] prdata, rd;
  fcc_mem_req_s mem_req;
  fcc_read_cfg_s read_cfg;
  logic [6:0] last_code;
  logic [7:0] last_data;
  logic last_err;
  int errors = 0, n_checks = 0, cycles = 0, n_flush = 0, n_pbuf = 0;
  int req_count, nr, nf, np;
  logic [6:0] codes [14] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h0f, 7'h1a, 7'h1c,
                            7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46};

  fcc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ahb_busy(ahb_busy), .mem_busy(mem_busy),
    .mem_done(mem_done), .security_bit(security_bit), .addr_in_user_row(addr_in_user_row),
    .lock_violation(lock_violation), .memory_fault(memory_fault),
    .pbuf_last_word(pbuf_last_word), .mem_req(mem_req), .cache_flush(cache_flush),
    .pbuf_clear(pbuf_clear), .power_reduced(power_reduced), .read_cfg(read_cfg));

  fcc_array_model array (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
    .slow(slow), .mem_busy(mem_busy), .mem_done(mem_done), .req_count(req_count),
    .last_code(last_code), .last_data(last_data));

  // ***********************************************************
  // clock, pulse counters and hang guard
  // ***********************************************************
  always #4 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (cache_flush === 1'b1) n_flush++;
    if (pbuf_clear === 1'b1) n_pbuf++;
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end

  task final_report();
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ***********************************************************
  // register bus: setup cycle, access cycle, pready always high
  // ***********************************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    rd = prdata;
    last_err = pslverr;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask

  task rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  // poll the ready flag before and after each command
  task wait_ready();
    int i;
    for (i = 0; i < 60; i++)
    begin
      rdr(FCC_OFF_IRQ_FLAGS);
      if (rd[FCC_FLAG_READY] === 1'b1)
        return;
    end
    errors++;
    final_report();
  endtask

  // key and code always go in one write, both low lanes together
  task key_cmd(input logic [7:0] k, input logic [6:0] c);
    wr(FCC_OFF_COMMAND, {16'h0, k, 1'b0, c}, 4'h3);
  endtask

  task do_cmd(input logic [6:0] c);
    wait_ready();
    nr = req_count;
    nf = n_flush;
    np = n_pbuf;
    key_cmd(FCC_KEY, c);
    wait_ready();
  endtask

  task clear_errors();
    wr(FCC_OFF_STATUS, 32'h1c, 4'h1);
    wr(FCC_OFF_IRQ_FLAGS, 32'h2, 4'h1);
  endtask

  task err_check(input string name, input logic [31:0] bit_mask);
    rdr(FCC_OFF_STATUS);
    chk(name, bit_mask, rd & bit_mask);
    rdr(FCC_OFF_IRQ_FLAGS);
    chk("error_flag", 32'h2, rd & 32'h2);
    clear_errors();
    rdr(FCC_OFF_IRQ_FLAGS);
    chk("error_cleared", 32'h0, rd & 32'h2);
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdr(FCC_OFF_CONFIG);
    chk("config_reset", FCC_CONFIG_RESET, rd);
    chk("wait_reset", 32'h0, 32'(read_cfg.flash_wait_states));
    chk("cache_reset", 32'h1, 32'(read_cfg.cache_on));
    wr(FCC_OFF_CONFIG, 32'hffff_ffff, 4'hf);
    rdr(FCC_OFF_CONFIG);
    chk("config_mask", FCC_CONFIG_MASK, rd);
    chk("cache_off", 32'h0, 32'(read_cfg.cache_on));
    chk("wait_max", 32'hf, 32'(read_cfg.flash_wait_states));
    // policies with three wait states, manual bit kept set
    for (int p = 0; p < 4; p++)
    begin
      wr(FCC_OFF_CONFIG, (p << 16) | 32'h86, 4'hf);
      // config flop updates at the access edge, look once it has settled
      @(negedge core_clk);
      chk("cache_on", 32'h1, 32'(read_cfg.cache_on));
      chk("policy", 32'(p), 32'(read_cfg.fetch_policy));
      if (p == 0) chk("miss_p0", 32'h0, 32'(read_cfg.miss_wait));
      if (p == 1) chk("miss_p1", 32'h1, 32'(read_cfg.miss_wait));
      if (p == 2) chk("hit_p2", 32'h3, 32'(read_cfg.hit_wait));
      if (p == 2) chk("miss_p2", 32'h3, 32'(read_cfg.miss_wait));
      if (p == 3) chk("miss_p3", 32'h0, 32'(read_cfg.miss_wait));
    end
    // command held back while the fetch bus is busy
    ahb_busy <= 1'b1;
    nr = req_count;
    key_cmd(FCC_KEY, FCC_ROW_WIPE_CMD);
    repeat (3) @(posedge core_clk);
    rdr(FCC_OFF_COMMAND);
    chk("pending_bit", 32'h1, 32'(rd[8]));
    chk("held_req", 32'(nr), 32'(req_count));
    ahb_busy <= 1'b0;
    wait_ready();
    chk("released_req", 32'(nr + 1), 32'(req_count));
    rdr(FCC_OFF_COMMAND);
    chk("issued_bit", 32'h0, 32'(rd[8]));
    // every documented code
    foreach (codes[i])
    begin
      do_cmd(codes[i]);
      case (codes[i])
        FCC_POWER_REDUCTION_ON_CMD: chk("pr_on", 32'h1, 32'(power_reduced));
        FCC_POWER_REDUCTION_OFF_CMD: chk("pr_off", 32'h0, 32'(power_reduced));
        FCC_PAGE_BUFFER_CLEAR_CMD: chk("pbuf", 32'(np + 1), 32'(n_pbuf));
        FCC_CACHE_FLUSH_CMD: chk("flush", 32'(nf + 1), 32'(n_flush));
        default:
        begin
          chk("req_count", 32'(nr + 1), 32'(req_count));
          chk("req_code", 32'(codes[i]), 32'(last_code));
        end
      endcase
      if (codes[i] == FCC_SECURITY_SET_CMD) chk("sec_byte", 32'h0, 32'(last_data));
    end
    // wrong key
    nr = req_count;
    key_cmd(8'h5a, FCC_ROW_WIPE_CMD);
    wait_ready();
    chk("bad_key_req", 32'(nr), 32'(req_count));
    err_check("bad_key_err", 32'h4);
    // key lane without its code lane counts as a bad key
    nr = req_count;
    wr(FCC_OFF_COMMAND, {16'h0, FCC_KEY, 1'b0, FCC_ROW_WIPE_CMD}, 4'h2);
    wait_ready();
    chk("split_req", 32'(nr), 32'(req_count));
    err_check("split_err", 32'h4);
    // second key while the array is still busy
    slow <= 1'b1;
    nr = req_count;
    key_cmd(FCC_KEY, FCC_ROW_WIPE_CMD);
    key_cmd(FCC_KEY, FCC_PAGE_PROGRAM_CMD);
    wait_ready();
    slow <= 1'b0;
    chk("busy_req", 32'(nr + 1), 32'(req_count));
    chk("busy_code", 32'(FCC_ROW_WIPE_CMD), 32'(last_code));
    err_check("busy_err", 32'h4);
    // aux codes refused when secured or outside the user row
    security_bit <= 1'b1;
    do_cmd(FCC_AUX_ROW_WIPE_CMD);
    chk("aux_sec", 32'(nr), 32'(req_count));
    err_check("aux_sec_err", 32'h4);
    security_bit <= 1'b0;
    addr_in_user_row <= 1'b0;
    do_cmd(FCC_AUX_PAGE_PROGRAM_CMD);
    chk("aux_row", 32'(nr), 32'(req_count));
    err_check("aux_row_err", 32'h4);
    addr_in_user_row <= 1'b1;
    // reserved codes do nothing
    do_cmd(7'h03);
    do_cmd(7'h47);
    chk("rsv_req", 32'(nr), 32'(req_count));
    chk("rsv_flush", 32'(nf), 32'(n_flush));
    rdr(FCC_OFF_STATUS);
    chk("rsv_err", 32'h0, rd & 32'h4);
    chk("mapped_err", 32'h0, 32'(last_err));
    // automatic page write on last buffer word
    wr(FCC_OFF_CONFIG, 32'h0, 4'hf);
    @(posedge core_clk);
    pbuf_last_word <= 1'b1;
    @(posedge core_clk);
    pbuf_last_word <= 1'b0;
    repeat (2) @(posedge core_clk);
    wait_ready();
    chk("auto_req", 32'(nr + 1), 32'(req_count));
    chk("auto_code", 32'(FCC_PAGE_PROGRAM_CMD), 32'(last_code));
    wr(FCC_OFF_CONFIG, FCC_CONFIG_RESET, 4'hf);
    @(posedge core_clk);
    pbuf_last_word <= 1'b1;
    @(posedge core_clk);
    pbuf_last_word <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("manual_req", 32'(nr + 1), 32'(req_count));
    // external error pulses
    @(posedge core_clk);
    lock_violation <= 1'b1;
    @(posedge core_clk);
    lock_violation <= 1'b0;
    err_check("lock_err", 32'h8);
    @(posedge core_clk);
    memory_fault <= 1'b1;
    @(posedge core_clk);
    memory_fault <= 1'b0;
    err_check("fault_err", 32'h10);
    // unmapped address
    rdr(8'h08);
    chk("unmapped_err", 32'h1, 32'(last_err));
    chk("unmapped_data", 32'h0, rd);
    chk("ready_out", 32'h1, 32'(pready));
    final_report();
  end
endmodule
